// File: uirl_link.sv
// uirl_link: host uart and optical stream bridge with modem lines and apb registers
// assumes synchronous inputs, one clock, a link stack reading the apb registers
`timescale 1ns/100ps
module uirl_link (
	// clock and reset
	input  wire logic              clock,
	input  wire logic              rst,
	// apb slave
	input  wire uirl_pkg::uirl_apb_req_t apbReq,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// host uart pins
	input  wire logic              hostTxIn,
	output logic                   hostRxOut,
	// host modem lines, all active low
	input  wire logic              ringN,
	input  wire logic              termReadyN,
	input  wire logic              reqToSendN,
	input  wire logic              carrierN,
	output logic                   setReadyN,
	output logic                   clearToSendN,
	// optical transceiver pins
	output logic                   optical_tx_out,
	input  wire logic              optical_rx_in
);
	import uirl_pkg::*;

	// complete state of the block
	typedef struct packed {
		logic        linkUp;     // stack says a primary holds a link
		logic        remoteDtr;  // primary's terminal-ready bit, stored only
		uirl_rx_t    hRx;        // receiver on the host line
		uirl_tx_t    hTx;        // transmitter to the host
		uirl_rx_t    oRx;        // optical receiver
		uirl_tx_t    oTx;        // optical transmitter
		logic [7:0]  hByte;      // byte from host waiting for the link
		logic        hValid;
		logic [7:0]  oByte;      // byte from link waiting for the host
		logic        oValid;
		logic [2:0]  remote;     // {carrier, terminal ready, ring} to primary
		logic        dsrN;
		logic        ctsN;
		logic [31:0] rdata;
		logic        rdy;
		logic        err;
	} uirl_state_t;

	uirl_state_t st_reg;   // registered state
	uirl_state_t st_next;  // next state

	// receiver step: mid-bit sampling, false starts are dropped
	function automatic uirl_rx_t rxStep(input uirl_rx_t s, input logic line);
		uirl_rx_t n;
		n = s;
		n.done = 1'b0;
		if (!s.busy) begin
			if (line == BIT_START) begin
				n.busy = 1'b1;
				n.cnt  = HALF_BIT;
				n.idx  = IDX_START;
			end
		end else if (s.cnt != '0) begin
			n.cnt = s.cnt - CNT_ONE;
		end else begin
			n.cnt = BIT_LAST;
			n.idx = s.idx + IDX_ONE;
			if (s.idx == IDX_START) begin
				// a glitch shorter than half a bit is no start
				if (line != BIT_START) n.busy = 1'b0;
			end else if (s.idx == IDX_STOP) begin
				// a frame with a low stop bit is discarded
				n.busy = 1'b0;
				n.done = (line == BIT_STOP);
			end else begin
				n.shift = {line, s.shift[7:1]}; // lsb arrives first
			end
		end
		return n;
	endfunction

	// transmitter step: loads a whole frame, shifts out one bit per bit time
	function automatic uirl_tx_t txStep(input uirl_tx_t s, input logic start,
		input logic [7:0] data);
		uirl_tx_t n;
		n = s;
		if (!s.busy) begin
			if (start) begin
				n.busy  = 1'b1;
				n.cnt   = BIT_LAST;
				n.idx   = IDX_START;
				n.shift = {BIT_STOP, data, BIT_START};
			end
		end else if (s.cnt != '0) begin
			n.cnt = s.cnt - CNT_ONE;
		end else begin
			n.cnt   = BIT_LAST;
			n.idx   = s.idx + IDX_ONE;
			n.shift = {LINE_IDLE, s.shift[9:1]};
			if (s.idx == IDX_STOP) n.busy = 1'b0;
		end
		n.line = n.busy ? n.shift[0] : LINE_IDLE;
		return n;
	endfunction

	// next-state logic for streams, modem lines and registers
	always_comb begin
		logic startOpt;
		logic startHost;
		logic access;
		startOpt  = 1'b0;
		startHost = 1'b0;
		access    = 1'b0;
		st_next   = st_reg;

		// host bytes in, held until the link takes them
		st_next.hRx = rxStep(st_reg.hRx, hostTxIn);
		// only a linked secondary sends; it never opens traffic itself
		startOpt = st_reg.hValid && st_reg.linkUp && !st_reg.oTx.busy;
		st_next.oTx = txStep(st_reg.oTx, startOpt, st_reg.hByte);
		if (startOpt) st_next.hValid = 1'b0;
		// set wins over the clear taken by the optical transmitter
		if (st_reg.hRx.done) begin
			st_next.hByte  = st_reg.hRx.shift;
			st_next.hValid = 1'b1;
		end

		// optical bytes in, passed to the host while it asks for them
		st_next.oRx = rxStep(st_reg.oRx, optical_rx_in);
		startHost = st_reg.oValid && !reqToSendN && !st_reg.hTx.busy;
		st_next.hTx = txStep(st_reg.hTx, startHost, st_reg.oByte);
		if (startHost) st_next.oValid = 1'b0;
		if (st_reg.oRx.done) begin
			st_next.oByte  = st_reg.oRx.shift;
			st_next.oValid = 1'b1;
		end

		// modem lines generated here, not from the primary's bits
		st_next.dsrN = !st_reg.linkUp;
		// hold the host off while its last byte is still parked
		st_next.ctsN = st_reg.hValid || st_reg.hRx.done || !st_reg.linkUp;
		// host levels turned into presence bits for the primary
		st_next.remote = {!carrierN, !termReadyN, !ringN};

		// apb: one wait state, then pready for one cycle
		st_next.rdy = 1'b0;
		st_next.err = 1'b0;
		access = apbReq.psel && apbReq.penable && !st_reg.rdy;
		if (access) begin
			st_next.rdy   = 1'b1;
			st_next.rdata = ZERO32;
			case (apbReq.paddr)
				OFF_CTRL: begin
					if (apbReq.pwrite) begin
						st_next.linkUp    = apbReq.pwdata[CTRL_LINK];
						st_next.remoteDtr = apbReq.pwdata[CTRL_RDTR];
					end else begin
						st_next.rdata[CTRL_LINK] = st_reg.linkUp;
						st_next.rdata[CTRL_RDTR] = st_reg.remoteDtr;
					end
				end
				OFF_STATUS: begin
					// raw pin levels and path occupancy
					st_next.rdata[7:0] = {st_reg.oTx.busy, st_reg.hTx.busy, st_reg.oValid,
						st_reg.hValid, reqToSendN, carrierN, termReadyN, ringN};
				end
				OFF_REMOTE: begin
					st_next.rdata[2:0] = st_reg.remote;
				end
				OFF_DATA: begin
					st_next.rdata[15:0] = {st_reg.oByte, st_reg.hByte};
				end
				default: begin
					st_next.err = 1'b1;
				end
			endcase
		end
	end

	// single state register
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_reg            <= '0;
			st_reg.hTx.line   <= LINE_IDLE;
			st_reg.oTx.line   <= LINE_IDLE;
			st_reg.dsrN       <= 1'b1;
			st_reg.ctsN       <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from the state register
	assign prdata         = st_reg.rdata;
	assign pready         = st_reg.rdy;
	assign pslverr        = st_reg.err;
	assign hostRxOut      = st_reg.hTx.line;
	assign optical_tx_out = st_reg.oTx.line;
	assign setReadyN      = st_reg.dsrN;
	assign clearToSendN   = st_reg.ctsN;

	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_dsr_link: assert property (##1 setReadyN == !$past(st_reg.linkUp))
		else $error("set-ready does not follow the link state");
	a_dtr_no_mirror: assert property ($changed(st_reg.remoteDtr) && $stable(st_reg.linkUp)
		|=> $stable(setReadyN) && $stable(clearToSendN))
		else $error("remote terminal-ready reached a local output");
	a_cts_hold: assert property (st_reg.hValid |=> clearToSendN)
		else $error("clear-to-send low while a host byte is parked");
	a_rts_gate: assert property ($rose(st_reg.hTx.busy) |-> !$past(reqToSendN))
		else $error("host output started while request-to-send high");
	a_no_initiate: assert property ($rose(st_reg.oTx.busy) |-> $past(st_reg.linkUp))
		else $error("optical transmit started without a link");
	a_start_bit: assert property ($rose(st_reg.hTx.busy) |-> hostRxOut == BIT_START)
		else $error("host frame does not open with a low start bit");
	a_idle_high: assert property (!st_reg.oTx.busy |-> optical_tx_out == LINE_IDLE)
		else $error("optical line not idle high");
	a_remote_bits: assert property (##1 st_reg.remote == {!$past(carrierN),
		!$past(termReadyN), !$past(ringN)})
		else $error("primary status bits do not track host lines");
	a_rx_capture: assert property (st_reg.hRx.done |=> st_reg.hValid
		&& st_reg.hByte == $past(st_reg.hRx.shift))
		else $error("received host byte not held");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");

	// stream framing, flow control and bus answers
	// an answer only follows a real access phase
	a_ready_access: assert property (pready |-> $past(apbReq.psel) && $past(apbReq.penable))
		else $error("pready without an access phase");

	// an error is only reported together with the answer
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr outside an answer");

	// an unmapped read returns nothing
	a_err_no_data: assert property (pslverr |-> prdata == ZERO32)
		else $error("unmapped access returned data");

	// a control write has landed by the time the answer shows
	a_link_write: assert property (pready && $past(apbReq.pwrite)
		&& $past(apbReq.paddr) == OFF_CTRL |-> st_reg.linkUp == $past(apbReq.pwdata[CTRL_LINK]))
		else $error("link bit not taken from the control write");

	// without a link the host is always held off
	a_cts_no_link: assert property (!st_reg.linkUp |=> clearToSendN)
		else $error("clear-to-send low without a link");

	// a freshly received byte holds the host off at once
	a_cts_on_done: assert property (st_reg.hRx.done |=> clearToSendN)
		else $error("clear-to-send low after a byte arrived");

	// set-ready only moves when the link state moves
	a_dsr_steady: assert property ($stable(st_reg.linkUp) |=> $stable(setReadyN))
		else $error("set-ready moved without a link change");

	// host line idles high between frames
	a_host_idle: assert property (!st_reg.hTx.busy |-> hostRxOut == LINE_IDLE)
		else $error("host line not idle high");

	// last bit of a host frame is a high stop bit
	a_host_stop: assert property (st_reg.hTx.busy && st_reg.hTx.idx == IDX_STOP |-> hostRxOut == BIT_STOP)
		else $error("host frame stop bit not high");

	// last bit of an optical frame is a high stop bit
	a_opt_stop: assert property (st_reg.oTx.busy && st_reg.oTx.idx == IDX_STOP |-> optical_tx_out == BIT_STOP)
		else $error("optical frame stop bit not high");

	// optical frames open with a low start bit
	a_opt_start: assert property ($rose(st_reg.oTx.busy) |-> optical_tx_out == BIT_START)
		else $error("optical frame does not open low");

	// a host bit stands for its whole bit time
	a_host_bit_hold: assert property (st_reg.hTx.busy && st_reg.hTx.cnt != '0 |=> $stable(hostRxOut))
		else $error("host bit changed inside its bit time");

	// an optical bit stands for its whole bit time
	a_opt_bit_hold: assert property (st_reg.oTx.busy && st_reg.oTx.cnt != '0 |=> $stable(optical_tx_out))
		else $error("optical bit changed inside its bit time");

	// a host frame never runs past its stop bit
	a_host_idx_range: assert property (st_reg.hTx.busy |-> st_reg.hTx.idx <= IDX_STOP)
		else $error("host frame longer than ten bits");

	// an optical frame never runs past its stop bit
	a_opt_idx_range: assert property (st_reg.oTx.busy |-> st_reg.oTx.idx <= IDX_STOP)
		else $error("optical frame longer than ten bits");

	// a host frame starts with a full start bit
	a_host_tx_load: assert property ($rose(st_reg.hTx.busy) |-> st_reg.hTx.cnt == BIT_LAST)
		else $error("host start bit shortened");

	// an optical frame starts with a full start bit
	a_opt_tx_load: assert property ($rose(st_reg.oTx.busy) |-> st_reg.oTx.cnt == BIT_LAST)
		else $error("optical start bit shortened");

	// host receiver first looks at the middle of the start bit
	a_host_rx_half: assert property ($rose(st_reg.hRx.busy) |-> st_reg.hRx.cnt == HALF_BIT)
		else $error("host receiver not aimed at mid start bit");

	// optical receiver first looks at the middle of the start bit
	a_opt_rx_half: assert property ($rose(st_reg.oRx.busy) |-> st_reg.oRx.cnt == HALF_BIT)
		else $error("optical receiver not aimed at mid start bit");

	// a low stop bit on the host line gives no byte
	a_host_bad_stop: assert property (st_reg.hRx.busy && st_reg.hRx.idx == IDX_STOP
		&& st_reg.hRx.cnt == '0 && hostTxIn != BIT_STOP |=> !st_reg.hRx.done)
		else $error("host frame with low stop accepted");

	// a low stop bit on the optical line gives no byte
	a_opt_bad_stop: assert property (st_reg.oRx.busy && st_reg.oRx.idx == IDX_STOP
		&& st_reg.oRx.cnt == '0 && optical_rx_in != BIT_STOP |=> !st_reg.oRx.done)
		else $error("optical frame with low stop accepted");

	// a received optical byte is parked for the host
	a_opt_rx_capture: assert property (st_reg.oRx.done |=> st_reg.oValid
		&& st_reg.oByte == $past(st_reg.oRx.shift))
		else $error("received optical byte not held");

	// without a link a parked host byte waits untouched
	a_host_parked: assert property (st_reg.hValid && !st_reg.hRx.done && !st_reg.linkUp
		|=> st_reg.hValid && $stable(st_reg.hByte))
		else $error("host byte left without a link");

	// a parked optical byte waits while the host refuses
	a_opt_parked: assert property (st_reg.oValid && reqToSendN && !st_reg.oRx.done |=> st_reg.oValid)
		else $error("optical byte dropped while host refuses");

	// no host frame starts while request-to-send is high
	a_rts_blocks: assert property (reqToSendN && !st_reg.hTx.busy |=> !st_reg.hTx.busy)
		else $error("host frame started against request-to-send");

	// no optical frame starts without a link
	a_opt_no_link: assert property (!st_reg.linkUp && !st_reg.oTx.busy |=> !st_reg.oTx.busy)
		else $error("optical frame started without a link");

	c_host_to_opt: cover property ($rose(st_reg.oTx.busy));
	c_opt_to_host: cover property ($rose(st_reg.hTx.busy));
	c_bad_addr:    cover property (pslverr);
	c_link_up:     cover property ($fell(setReadyN));
	c_dtr_only:    cover property ($changed(st_reg.remoteDtr) && $stable(st_reg.linkUp));
endmodule // uirl_link

// File: uirl_pkg.sv
// uirl_pkg: constants, register map and state carriers of the host-facing ir link block
// assumes a single 25 MHz clock and an apb master with 32-bit data
// What this block does
// - take host serial bytes on data input
// - send serial bytes to host on data output
// - forward host ring level to primary station
// - set-ready low while ir link exists
// - remote terminal-ready bit never drives local outputs
// - forward host terminal-ready as primary set-ready bit
// - clear-to-send high tells host hold off
// - withhold host output while request-to-send high
// - forward host carrier-detect to primary station
// - drive optical transmit stream on own pin
// - take optical receive stream on own pin
// - act as flow-controlled serial port for host
// - secondary only, never start link traffic
// - timing derived from the 25 MHz core clock
package uirl_pkg;
	// timing
	localparam int unsigned CLK_HZ   = 25000000; // core clock rate
	localparam int unsigned OSC_HZ   = 11059200; // documented oscillator rate
	localparam int unsigned BAUD     = 9600;     // serial rate on both streams
	localparam int unsigned BIT_CYC  = CLK_HZ / BAUD;
	localparam int unsigned CNT_W    = 12;
	localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CYC - 1);
	localparam logic [CNT_W-1:0] HALF_BIT = CNT_W'(BIT_CYC / 2);
	localparam logic [CNT_W-1:0] CNT_ONE  = 12'h001;
	// frame layout
	localparam logic [3:0] IDX_START = 4'h0;
	localparam logic [3:0] IDX_STOP  = 4'h9;
	localparam logic [3:0] IDX_ONE   = 4'h1;
	localparam logic       LINE_IDLE = 1'b1;
	localparam logic       BIT_START = 1'b0;
	localparam logic       BIT_STOP  = 1'b1;
	// register byte addresses
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_REMOTE = 8'h08;
	localparam logic [7:0] OFF_DATA   = 8'h0c;
	// control fields
	localparam int unsigned CTRL_LINK = 0;
	localparam int unsigned CTRL_RDTR = 1;
	localparam logic [31:0] ZERO32 = 32'h0000_0000;
	// serial receiver state
	typedef struct packed {
		logic             busy;
		logic             done;
		logic [CNT_W-1:0] cnt;
		logic [3:0]       idx;
		logic [7:0]       shift;
	} uirl_rx_t;
	// serial transmitter state
	typedef struct packed {
		logic             busy;
		logic             line;
		logic [CNT_W-1:0] cnt;
		logic [3:0]       idx;
		logic [9:0]       shift;
	} uirl_tx_t;
	// apb request as one carrier
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} uirl_apb_req_t;
endpackage : uirl_pkg

// File: uirl_host_model.sv
// uirl_host_model: host microcontroller uart partner, one byte per frame
// assumes the bench clock and BIT_CYC clocks per serial bit
`timescale 1ns/100ps
module uirl_host_model import uirl_pkg::*; (
	// clock
	input  wire logic       clock,
	// serial lines and flow control
	input  wire logic       rxLine,
	output logic            txLine,
	input  wire logic       ctsN,
	// received byte report, strobe lasts one cycle
	output logic [7:0]      gotByte,
	output logic            gotStb
);
	int i; // bit index of the receiver
	// idle high between frames
	initial begin
		txLine = LINE_IDLE;
		gotStb = 1'b0;
		gotByte = 8'h00;
	end
	// send one frame; a real host honours clear-to-send, so we wait (bounded)
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {BIT_STOP, b, BIT_START};
		for (int n = 0; n < 1000 && ctsN !== 1'b0; n++) @(posedge clock);
		for (int k = 0; k < 10; k++) begin
			txLine <= f[k];
			repeat (BIT_CYC) @(posedge clock);
		end
	endtask
	// decode frames from the device mid-bit; a low stop gives no strobe
	always begin
		@(negedge rxLine);
		repeat (HALF_BIT) @(posedge clock);
		for (i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge clock);
			gotByte[i] <= rxLine;
		end
		repeat (BIT_CYC) @(posedge clock);
		gotStb <= rxLine;
		@(posedge clock);
		gotStb <= 1'b0;
	end
endmodule // uirl_host_model

// File: ir_link_host_uart_side_bench.sv
// bench: apb master, optical line driver and monitors around uirl_link
// assumes the host model file; expected results wait in queues for the monitors
`timescale 1ns/100ps
module ir_link_host_uart_side_bench import uirl_pkg::*;;
	logic clock, rst, pready, pslverr, hostTxIn, hostRxOut, ringN, termReadyN;
	logic reqToSendN, carrierN, setReadyN, clearToSendN, optical_tx_out, optical_rx_in;
	logic gotStb, bad;
	logic [31:0] prdata;
	logic [7:0] gotByte, lf, b1, b2, ob;
	logic [2:0] m;
	logic [33:0] e; // care, error, data
	uirl_apb_req_t req;
	logic [33:0] apbQ[$];
	logic [7:0] optQ[$], hostQ[$];
	int mismatches, compares, optSeen, j, n;
	uirl_link uut (.clock(clock), .rst(rst), .apbReq(req), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .hostTxIn(hostTxIn), .hostRxOut(hostRxOut), .ringN(ringN),
		.termReadyN(termReadyN), .reqToSendN(reqToSendN), .carrierN(carrierN),
		.setReadyN(setReadyN), .clearToSendN(clearToSendN),
		.optical_tx_out(optical_tx_out), .optical_rx_in(optical_rx_in));
	uirl_host_model host (.clock(clock), .rxLine(hostRxOut), .txLine(hostTxIn),
		.ctsN(clearToSendN), .gotByte(gotByte), .gotStb(gotStb));
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic chk(input logic ok, input string msg);
		compares++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// one apb transfer; the expectation is queued before the request goes out
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic care, input logic err, input logic [31:0] x);
		int k;
		apbQ.push_back({care, err, x});
		@(posedge clock);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clock);
		req.penable <= 1'b1;
		k = 0;
		do begin @(posedge clock); k++; end while (pready !== 1'b1 && k < 50);
		if (k >= 50) chk(1'b0, "apb hang");
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task automatic opt_send(input logic [7:0] b);
		logic [9:0] f;
		f = {BIT_STOP, b, BIT_START};
		for (int k = 0; k < 10; k++) begin
			optical_rx_in <= f[k];
			repeat (BIT_CYC) @(posedge clock);
		end
	endtask
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// apb answers are compared in the edge where pready is seen
	always @(posedge clock) if (pready === 1'b1) begin
		e = (apbQ.size() > 0) ? apbQ.pop_front() : 34'h0;
		chk(pslverr === e[32] && (!e[33] || prdata === e[31:0]), "apb answer");
	end
	// bytes reaching the host; an unexpected one is a fault too
	always @(posedge clock) if (gotStb === 1'b1) begin
		chk(hostQ.size() > 0 && gotByte === hostQ[0], "host byte");
		if (hostQ.size() > 0) void'(hostQ.pop_front());
	end
	// optical decoder; the device must never start traffic by itself
	always begin
		@(negedge optical_tx_out);
		repeat (HALF_BIT) @(posedge clock);
		for (j = 0; j < 8; j++) begin
			repeat (BIT_CYC) @(posedge clock);
			ob[j] = optical_tx_out;
		end
		repeat (BIT_CYC) @(posedge clock);
		chk(optQ.size() > 0 && optical_tx_out === BIT_STOP && ob === optQ[0], "opt byte");
		if (optQ.size() > 0) void'(optQ.pop_front());
		optSeen++;
	end
	initial begin
		repeat (90000) @(posedge clock);
		chk(1'b0, "timeout");
		give_verdict();
	end
	initial begin
		lf = 8'h5f;
		rst = 1'b1;
		req = '0;
		{ringN, termReadyN, reqToSendN, carrierN, optical_rx_in} = 5'h1f;
		repeat (3) @(posedge clock);
		chk(setReadyN === 1 && clearToSendN === 1 && hostRxOut === 1, "reset");
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		$display("test reset done");
		for (int t = 0; t < 2; t++) begin
			lf = lfsr(lf);
			m = lf[2:0];
			{carrierN, termReadyN, ringN} <= m;
			apb(0, OFF_STATUS, 0, 1, 0, {28'h0, 1'b1, m});
			apb(0, OFF_REMOTE, 0, 1, 0, {29'h0, ~m});
		end
		$display("test modem done");
		apb(0, 8'h10, 0, 0, 1, 0);
		apb(1, OFF_STATUS, 32'hffff_ffff, 0, 0, 0);
		apb(0, OFF_CTRL, 0, 1, 0, 0);
		chk(setReadyN === 1 && clearToSendN === 1, "no link");
		apb(1, OFF_CTRL, 32'h3, 0, 0, 0);
		apb(0, OFF_CTRL, 0, 1, 0, 32'h3);
		chk(setReadyN === 0 && clearToSendN === 0, "link");
		apb(1, OFF_CTRL, 32'h1, 0, 0, 0);
		apb(0, OFF_CTRL, 0, 1, 0, 32'h1);
		chk(setReadyN === 0 && clearToSendN === 0, "dtr no mirror");
		$display("test apb done");
		b1 = lfsr(lf);
		b2 = lfsr(b1);
		fork
			begin optQ.push_back(b1); host.send(b1); end
			begin hostQ.push_back(b2); opt_send(b2); end
		join
		bad = 1'b0;
		repeat (3000) @(posedge clock) if (hostRxOut !== 1'b1) bad = 1'b1;
		chk(!bad, "held");
		reqToSendN <= 1'b0;
		for (n = 0; n < 60000 && (optSeen < 1 || hostQ.size() > 0); n++) @(posedge clock);
		chk(n < 60000, "serial wait");
		apb(0, OFF_DATA, 0, 1, 0, {16'h0, b2, b1});
		$display("test serial done");
		give_verdict();
	end
endmodule // ir_link_host_uart_side_bench
